//--- common/sepc_pkg.sv
// Constants for the secure EEPROM program-control block
package sepc_pkg;
  localparam int          ADDR_W      = 11;
  localparam int          MEM_BITS    = 1568;
  localparam logic [10:0] ADDR_LAST   = 11'h61F;  // 1567
  localparam logic [10:0] ADDR_ZERO   = 11'h000;
  localparam logic [10:0] WORD_MASK   = 11'h7F0;  // 16-bit word base
  localparam logic [10:0] FAB_LO      = 11'h000;  // fabrication_region 0..15
  localparam logic [10:0] FAB_HI      = 11'h00F;
  localparam logic [10:0] ZONE1_LO    = 11'h0B0;  // first_app_zone 176..687
  localparam logic [10:0] ZONE1_HI    = 11'h2AF;
  localparam logic [10:0] KEY1_LO     = 11'h2B0;  // zone_one_erase_key 688..735
  localparam logic [10:0] KEY1_HI     = 11'h2DF;
  localparam logic [10:0] TRIG1       = 11'h2E0;  // 736
  localparam logic [10:0] ZONE2_LO    = 11'h2E0;  // second_app_zone 736..1247
  localparam logic [10:0] ZONE2_HI    = 11'h4DF;
  localparam logic [10:0] KEY2_LO     = 11'h4E0;  // zone_two_erase_key 1248..1279
  localparam logic [10:0] KEY2_HI     = 11'h4FF;
  localparam logic [10:0] TALLY_LO    = 11'h500;  // zone_two_erase_tally 1280..1407
  localparam logic [10:0] TALLY_HI    = 11'h57F;
  localparam logic [10:0] TRIG2       = 11'h500;  // 1280
  localparam logic [10:0] BLOCK_LO    = 11'h5A0;  // 1440
  localparam logic [10:0] BLOCK_HI    = 11'h5AF;  // 1455
  localparam logic [10:0] MAKER_LO    = 11'h5B0;  // maker_region 1456..1471
  localparam logic [10:0] MAKER_HI    = 11'h5BF;
  localparam logic [10:0] MTEST_LO    = 11'h600;  // memory_test_region 1536..1551
  localparam logic [10:0] MTEST_HI    = 11'h60F;
  localparam logic        ERASED      = 1'b1;

  typedef enum logic [2:0] {
    SEPC_ACT_NONE,
    SEPC_ACT_BIT,
    SEPC_ACT_WORD,
    SEPC_ACT_ZONE1,
    SEPC_ACT_ZONE2,
    SEPC_ACT_BLOCK
  } sepc_act_t;
endpackage

//--- core/sepc_program_control.sv
// Program control of a bit-serial secure EEPROM: write, erase, key compare
//
// Operation
// - Terminating falling edge never advances address
// - Write clears bit; forbidden writes suppressed
// - Zone writes need code valid, level-2 permits
// - Non-zone erase sets whole 16-bit word
// - Forbidden erases are suppressed
// - Level-1 zone erase: code valid, word erase
// - Limited mode allows at most 128 zone two erases
// - Level-2 zone one erase needs permits
// - Level-2 zone two erase needs permits
// - Tally erase clears zone two, tally unchanged
// - Trigger bit erase clears zone, word kept
// - Zone one and unlimited mode never limited
// - Block operation: level 1, range, pin high
// - Block operation fills all but reserved regions
// - Address advances on falling edge, reset low
// - Compare data latched rising, compared falling
// - Address wraps from 1567 to zero
module sepc_program_control
  import sepc_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              reset,
  input  wire logic              cardClk,
  input  wire logic              addrReset,
  input  wire logic              program_control,
  input  wire logic              personalization_pin,
  input  wire logic              issuerFuseIntact,
  input  wire logic              limited_erase_mode,
  input  wire logic              code_valid_flag,
  input  wire logic              zone_one_write_permit,
  input  wire logic              zone_two_write_permit,
  input  wire logic              dataIn,
  output logic                   dataOut,
  output logic                   dataOe,
  output logic [ADDR_W-1:0]      bitAddress,
  output logic                   zone_one_erase_permit,
  output logic                   zone_two_erase_permit,
  output logic                   programBusy
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic inRange(input logic [10:0] a, input logic [10:0] lo, input logic [10:0] hi);
    inRange = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic isReserved(input logic [10:0] a);
    isReserved = inRange(a, FAB_LO, FAB_HI) || inRange(a, MTEST_LO, MTEST_HI) || inRange(a, MAKER_LO, MAKER_HI);
  endfunction

  // Which stored bits one finished operation touches
  function automatic logic bitHit(input logic [10:0] i, input sepc_act_t act, input logic [10:0] a);
    case (act)
      SEPC_ACT_BIT:   bitHit = (i == a);
      SEPC_ACT_WORD:  bitHit = ((i & WORD_MASK) == (a & WORD_MASK));
      SEPC_ACT_ZONE1: bitHit = inRange(i, ZONE1_LO, ZONE1_HI);
      SEPC_ACT_ZONE2: bitHit = inRange(i, ZONE2_LO, ZONE2_HI);
      SEPC_ACT_BLOCK: bitHit = !isReserved(i);
      default:        bitHit = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic                 clkPrev;
  logic                 opActive;
  logic                 opErase;
  logic                 cmpData;
  logic                 keyGood;
  logic                 tallyArmed;
  logic [MEM_BITS-1:0]  mem;
  logic                 next_clkPrev;
  logic                 next_opActive;
  logic                 next_opErase;
  logic                 next_cmpData;
  logic                 next_keyGood;
  logic                 next_tallyArmed;
  logic [ADDR_W-1:0]    next_bitAddress;
  logic                 next_eOne;
  logic                 next_eTwo;
  logic                 next_dataOe;
  sepc_act_t            act;

  wire logic clkRise  = cardClk && !clkPrev;
  wire logic clkFall  = !cardClk && clkPrev;
  // Pin low forces level 2 even with an intact fuse
  wire logic levelOne = issuerFuseIntact && personalization_pin;
  wire logic curBit   = mem[bitAddress];
  wire logic inZone1  = inRange(bitAddress, ZONE1_LO, ZONE1_HI);
  wire logic inZone2  = inRange(bitAddress, ZONE2_LO, ZONE2_HI);
  wire logic inTally  = inRange(bitAddress, TALLY_LO, TALLY_HI);
  wire logic inKey1   = inRange(bitAddress, KEY1_LO, KEY1_HI);
  wire logic inKey2   = inRange(bitAddress, KEY2_LO, KEY2_HI);
  wire logic inBlock  = inRange(bitAddress, BLOCK_LO, BLOCK_HI);
  wire logic opDone   = clkFall && opActive;

  ////////////////////////////////////////////////////////////////////////////
  // Permission decode of the operation that ends on this falling edge
  always_comb begin
    act = SEPC_ACT_NONE;
    if (levelOne && code_valid_flag && inBlock) begin
      act = SEPC_ACT_BLOCK;
    end else if (!opErase) begin
      if (inZone1) begin
        if (code_valid_flag && (levelOne || zone_one_write_permit)) act = SEPC_ACT_BIT;
      end else if (inZone2) begin
        if (code_valid_flag && (levelOne || zone_two_write_permit)) act = SEPC_ACT_BIT;
      end else if (inTally && !levelOne) begin
        if (limited_erase_mode && zone_two_erase_permit) act = SEPC_ACT_BIT;
      end else if (levelOne && code_valid_flag && !isReserved(bitAddress)) begin
        act = SEPC_ACT_BIT;
      end
    end else if (levelOne) begin
      if (code_valid_flag && !isReserved(bitAddress)) act = SEPC_ACT_WORD;
    end else if (bitAddress == TRIG1) begin
      // Zone one is never tally limited
      if (code_valid_flag && zone_one_erase_permit) act = SEPC_ACT_ZONE1;
    end else if (inTally && limited_erase_mode) begin
      // Only the tally bit just written in level 2 unlocks an erase, so 128 bits cap it
      if (code_valid_flag && zone_two_erase_permit && tallyArmed) act = SEPC_ACT_ZONE2;
    end else if (bitAddress == TRIG2) begin
      if (code_valid_flag && zone_two_erase_permit) act = SEPC_ACT_ZONE2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Handshake, address counter, key compare and line drive
  always_comb begin
    next_clkPrev    = cardClk;
    next_opActive   = opActive;
    next_opErase    = opErase;
    next_cmpData    = cmpData;
    next_keyGood    = keyGood;
    next_tallyArmed = tallyArmed;
    next_bitAddress = bitAddress;
    next_eOne       = zone_one_erase_permit;
    next_eTwo       = zone_two_erase_permit;
    if (clkRise) begin
      if (program_control) begin
        next_opActive = 1'b1;
        next_opErase  = dataIn;
      end else begin
        next_cmpData  = dataIn;
      end
    end
    if (opDone) begin
      next_opActive = 1'b0;
      // Armed only by a level-2 write that really turned a tally bit from one to zero
      next_tallyArmed = (act == SEPC_ACT_BIT) && inTally && !levelOne && !opErase && curBit;
    end else if (clkFall && !addrReset) begin
      next_tallyArmed = 1'b0;
      if (inKey1 || inKey2) begin
        if (bitAddress == KEY1_LO || bitAddress == KEY2_LO) begin
          next_keyGood = (cmpData == curBit);
        end else begin
          next_keyGood = keyGood && (cmpData == curBit);
        end
        if (bitAddress == KEY1_HI && keyGood && cmpData == curBit && code_valid_flag) next_eOne = 1'b1;
        if (bitAddress == KEY2_HI && keyGood && cmpData == curBit && code_valid_flag) next_eTwo = 1'b1;
      end
      if (bitAddress == ADDR_LAST) begin
        next_bitAddress = ADDR_ZERO;
      end else begin
        next_bitAddress = bitAddress + 11'h001;
      end
    end
    // Address reset outside an operation homes the address, clears both erase permits and tallyArmed
    if (addrReset && !opActive) begin
      next_bitAddress = ADDR_ZERO;
      next_eOne       = 1'b0;
      next_eTwo       = 1'b0;
      next_tallyArmed = 1'b0;
    end
    // Open drain: pull low only for a stored zero, and never during programming
    next_dataOe = !mem[next_bitAddress] && !program_control && !next_opActive;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      clkPrev               <= 1'b0;
      opActive              <= 1'b0;
      opErase               <= 1'b0;
      cmpData               <= 1'b0;
      keyGood               <= 1'b0;
      tallyArmed            <= 1'b0;
      bitAddress            <= ADDR_ZERO;
      zone_one_erase_permit <= 1'b0;
      zone_two_erase_permit <= 1'b0;
      dataOe                <= 1'b0;
    end else begin
      clkPrev               <= next_clkPrev;
      opActive              <= next_opActive;
      opErase               <= next_opErase;
      cmpData               <= next_cmpData;
      keyGood               <= next_keyGood;
      tallyArmed            <= next_tallyArmed;
      bitAddress            <= next_bitAddress;
      zone_one_erase_permit <= next_eOne;
      zone_two_erase_permit <= next_eTwo;
      dataOe                <= next_dataOe;
    end
  end

  assign dataOut     = 1'b0;
  assign programBusy = opActive;

  ////////////////////////////////////////////////////////////////////////////
  // Storage: each bit takes the erase or write level when the finished operation hits it
  for (genvar i = 0; i < MEM_BITS; i++) begin : g_bit
    logic next_cell;
    always_comb begin
      next_cell = mem[i];
      if (opDone && bitHit(11'(i), act, bitAddress)) next_cell = opErase;
    end
    always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
        mem[i] <= ERASED;
      end else begin
        mem[i] <= next_cell;
      end
    end
  end

endmodule // sepc_program_control

//--- tb/sepc_host_model.sv
// Reader host model: card clock, address reset, program control, open-drain data
module sepc_host_model (
  input  wire logic ref_clk,
  input  wire logic dataOe,
  output logic      cardClk,
  output logic      addrReset,
  output logic      program_control,
  output wire logic dataIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hostEn = 1'b0;
  logic hostVal = 1'b0;
  // Pull-up on the line; either party may pull it low
  assign dataIn = (hostEn ? hostVal : 1'b1) && !dataOe;
  initial begin
    cardClk = 1'b0;
    addrReset = 1'b0;
    program_control = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic step(input logic d);
    hostEn = 1'b1;
    hostVal = d;
    hold(2);
    cardClk = 1'b1;
    hold(3);
    cardClk = 1'b0;
    hostEn = 1'b0;
    hold(3);
  endtask
  task automatic prog(input logic erase);
    program_control = 1'b1;
    hostEn = 1'b1;
    hostVal = erase;
    hold(2);
    cardClk = 1'b1;
    hold(3);
    program_control = 1'b0;
    hostEn = 1'b0;
    hold(8);
    cardClk = 1'b0;
    hold(3);
  endtask
  // Clock stays low while the address is sent home
  task automatic home();
    addrReset = 1'b1;
    hold(3);
    addrReset = 1'b0;
    hold(2);
  endtask
endmodule // sepc_host_model

//--- tb/sepc_program_control_assertions.sv
// Checker for address stepping, program handshake and line release
module sepc_program_control_assertions
  import sepc_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic        cardClk,
  input wire logic        addrReset,
  input wire logic        program_control,
  input wire logic        dataOe,
  input wire logic [10:0] bitAddress,
  input wire logic        programBusy,
  input wire logic        zone_one_erase_permit,
  input wire logic        zone_two_erase_permit
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic prevClk;
  always_ff @(posedge ref_clk or posedge reset)
    if (reset) prevClk <= 1'b0;
    else prevClk <= cardClk;
  sequence s_rise; cardClk && !prevClk; endsequence
  sequence s_fall; !cardClk && prevClk; endsequence
  sequence s_step; s_fall ##0 (!programBusy && !addrReset); endsequence
  a_busy_start: assert property (s_rise ##0 program_control |=> programBusy) else $error("busy not raised");
  a_busy_end: assert property (s_fall ##0 programBusy |=> !programBusy) else $error("busy not cleared");
  a_end_hold: assert property (s_fall ##0 programBusy |=> $stable(bitAddress)) else $error("op end moved addr");
  a_step_next: assert property (s_step ##0 bitAddress != ADDR_LAST |=> bitAddress == $past(bitAddress) + 11'h001)
    else $error("address did not step");
  a_addr_wrap: assert property (s_step ##0 bitAddress == ADDR_LAST |=> bitAddress == ADDR_ZERO) else $error("no wrap");
  a_home_zero: assert property (addrReset && !programBusy |=> bitAddress == ADDR_ZERO) else $error("no home");
  a_permit_drop: assert property (addrReset && !programBusy |=> !zone_one_erase_permit && !zone_two_erase_permit)
    else $error("permit kept");
  a_line_free: assert property (program_control && $past(program_control) |-> !dataOe) else $error("line driven");
  a_busy_quiet: assert property (programBusy && $past(programBusy) |-> !dataOe) else $error("line driven in op");
endmodule // sepc_program_control_assertions
bind sepc_program_control sepc_program_control_assertions u_chk (.ref_clk, .reset, .cardClk, .addrReset,
  .program_control, .dataOe, .bitAddress, .programBusy, .zone_one_erase_permit, .zone_two_erase_permit);

//--- tb/testbench.sv
// Self-checking bench: bit writes and erases, key match, zone and block operations
module testbench
  import sepc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [10:0] a; logic l1, cv, pw; logic [1:0] op; logic ex;} sepc_row_t;
  logic ref_clk = 1'b0, reset = 1'b1, pin = 1'b1, cv = 1'b0, pw = 1'b0, fuse = 1'b1, lim = 1'b0;
  logic cardClk, addrReset, program_control, dataIn, dataOut, dataOe, programBusy, perm1, perm2;
  logic [10:0] bitAddress;
  int num_errors = 0, samples_checked = 0;
  // Op 0 write, 1 erase, 2 look only; ex is the expected pull-low
  sepc_row_t rows[11] = '{
    '{11'h0C8, 1'b1, 1'b0, 1'b0, 2'h0, 1'b0}, '{11'h0C9, 1'b1, 1'b1, 1'b0, 2'h0, 1'b1},
    '{11'h320, 1'b0, 1'b1, 1'b0, 2'h0, 1'b0}, '{11'h321, 1'b0, 1'b1, 1'b1, 2'h0, 1'b1},
    '{11'h321, 1'b0, 1'b1, 1'b1, 2'h1, 1'b1}, '{11'h029, 1'b1, 1'b1, 1'b0, 2'h0, 1'b1},
    '{11'h028, 1'b1, 1'b1, 1'b0, 2'h1, 1'b0}, '{11'h029, 1'b1, 1'b1, 1'b0, 2'h2, 1'b0},
    '{11'h0D1, 1'b1, 1'b1, 1'b0, 2'h0, 1'b1}, '{11'h0D0, 1'b1, 1'b1, 1'b0, 2'h1, 1'b0},
    '{11'h0D1, 1'b1, 1'b1, 1'b0, 2'h2, 1'b0}};
  always #2.5 ref_clk = ~ref_clk;
  sepc_host_model host (.ref_clk, .dataOe, .cardClk, .addrReset, .program_control, .dataIn);
  sepc_program_control dut (.ref_clk, .reset, .cardClk, .addrReset, .program_control, .personalization_pin(pin),
    .issuerFuseIntact(fuse), .limited_erase_mode(lim), .code_valid_flag(cv), .zone_one_write_permit(pw),
    .zone_two_write_permit(pw), .dataIn, .dataOut, .dataOe, .bitAddress, .zone_one_erase_permit(perm1),
    .zone_two_erase_permit(perm2), .programBusy);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    if (num_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic goto(input logic [10:0] a);
    if (bitAddress > a) host.home();
    for (int i = 0; i < 1600 && bitAddress !== a; i++) host.step(1'b1);
    if (bitAddress !== a) begin
      num_errors++;
      results();
    end
  endtask
  initial begin
    repeat (6) @(negedge ref_clk);
    reset = 1'b0;
    host.hold(2);
    check(16'({dataOut, perm1, perm2, programBusy, dataOe, bitAddress}), 16'h0000);
    foreach (rows[i]) begin
      pin = rows[i].l1;
      cv = rows[i].cv;
      pw = rows[i].pw;
      goto(rows[i].a);
      if (rows[i].op != 2'h2) host.prog(rows[i].op[0]);
      check(16'(dataOe), 16'(rows[i].ex));
    end
    // Zone one erase through its key, then the trigger word is looked at
    pin = 1'b0;
    pw = 1'b1;
    goto(11'h2E1);
    host.prog(1'b0);
    goto(11'h12C);
    host.prog(1'b0);
    goto(KEY1_LO);
    check(16'(perm1), 16'h0000);
    repeat (48) host.step(1'b1);
    check(16'({perm1, bitAddress}), 16'({1'b1, TRIG1}));
    host.prog(1'b1);
    host.step(1'b1);
    check(16'(dataOe), 16'h0001);
    goto(11'h12C);
    check(16'(dataOe), 16'h0000);
    // Limited mode, level 2 by a blown fuse: zone two opens only after a fresh tally write
    pin = 1'b1;
    fuse = 1'b0;
    lim = 1'b1;
    goto(ZONE2_HI);
    host.prog(1'b0);
    goto(KEY2_LO);
    repeat (32) host.step(1'b1);
    check(16'({perm2, bitAddress}), 16'({1'b1, TALLY_LO}));
    host.prog(1'b1);
    host.step(1'b1);
    // A tally bit cleared in level 1 is stale and must not unlock an erase
    fuse = 1'b1;
    host.prog(1'b0);
    fuse = 1'b0;
    host.prog(1'b1);
    goto(ZONE2_HI);
    check(16'(dataOe), 16'h0001);
    goto(KEY2_LO);
    repeat (32) host.step(1'b1);
    host.prog(1'b0);
    host.prog(1'b1);
    check(16'({perm2, dataOe, bitAddress}), 16'({2'h3, TALLY_LO}));
    goto(ZONE2_HI);
    check(16'(dataOe), 16'h0000);
    fuse = 1'b1;
    goto(BLOCK_LO);
    host.prog(1'b0);
    goto(11'h005);
    check(16'(dataOe), 16'h0000);
    goto(11'h014);
    check(16'(dataOe), 16'h0001);
    // Reset in mid-run brings back an erased array at address zero
    reset = 1'b1;
    host.hold(2);
    reset = 1'b0;
    host.hold(2);
    check(16'({perm2, programBusy, dataOe, bitAddress}), 16'h0000);
    goto(11'h014);
    check(16'(dataOe), 16'h0000);
    goto(ADDR_LAST);
    host.step(1'b1);
    check(16'(bitAddress), 16'(ADDR_ZERO));
    results();
  end
endmodule // testbench
